/* logic/ictr_pkg.sv */
// Package: register map, field layout and reset values of the channel trim bank
package ictr_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // Printed offsets are word indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_OFFSET = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_FSADJ = 4'h3;
    localparam logic [ADDR_W-1:0] IDX_MODE = 4'h4;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h5;
    localparam int OFS_MAG_HI = 15;
    localparam int OFS_MAG_LO = 8;
    localparam int OFS_SIGN = 7;
    localparam int FS_HI = 15;
    localparam int FS_LO = 7;
    localparam int OFS_MAG_W = OFS_MAG_HI - OFS_MAG_LO + 1;
    localparam int FS_W = FS_HI - FS_LO + 1;
    localparam logic [REG_W-1:0] OFFSET_RST = 16'h007F;
    localparam logic [REG_W-1:0] FSADJ_RST = 16'h807F;
    localparam logic [OFS_MAG_W-1:0] OFS_MAG_ZERO = 8'h00;
    localparam logic [FS_W-1:0] FS_MIDSCALE = 9'h100;
    localparam logic [6:0] FILL_ONES = 7'h7F;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
endpackage

/* logic/ictr_wr_latch.sv */
// Single write-only 16-bit trim register with reset value
`timescale 1ns/1ps
`default_nettype none
module ictr_wr_latch #(
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] value
);
    logic [15:0] value_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            value_q <= RST_VAL;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end
    assign value = value_q;
endmodule
`default_nettype wire

/* logic/ictr_top.sv */
// Top: first-channel offset and full-scale trim registers on Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module ictr_top (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [ictr_pkg::ADDR_W+1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [ictr_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [ictr_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [ictr_pkg::OFS_MAG_W-1:0] OFFSET_MAG,
    output logic OFFSET_NEG,
    output logic [ictr_pkg::FS_W-1:0] FS_CODE
);
    ////////////////////////////////////////////////////////////////////////
    // Local bit positions of the bus words
    localparam int WORD_LSB = 2;
    localparam int LANE_W = 2;
    localparam int DATA_LSB = 0;
    localparam int MODE_BIT = 0;
    localparam int STAT_SIGN = ictr_pkg::OFS_MAG_W;
    localparam int STAT_FS_LO = STAT_SIGN + 1;
    localparam int STAT_FS_HI = STAT_FS_LO + ictr_pkg::FS_W - 1;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Word index match, used by every register select
    function automatic logic f_hit(
        input logic [ictr_pkg::ADDR_W-1:0] sel,
        input logic [ictr_pkg::ADDR_W-1:0] target
    );
        return sel == target;
    endfunction

    // Stored trim fields as one read word, upper bits zero
    function automatic logic [ictr_pkg::DATA_W-1:0] f_status(
        input logic [ictr_pkg::FS_W-1:0] code,
        input logic neg,
        input logic [ictr_pkg::OFS_MAG_W-1:0] mag
    );
        logic [ictr_pkg::DATA_W-1:0] word;
        word = ictr_pkg::RD_ZERO;
        word[ictr_pkg::OFS_MAG_W-1:0] = mag;
        word[STAT_SIGN] = neg;
        word[STAT_FS_HI:STAT_FS_LO] = code;
        return word;
    endfunction

    // Mode flag as one read word
    function automatic logic [ictr_pkg::DATA_W-1:0] f_mode(
        input logic ext
    );
        logic [ictr_pkg::DATA_W-1:0] word;
        word = ictr_pkg::RD_ZERO;
        word[MODE_BIT] = ext;
        return word;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and stored fields
    logic ack_q;
    logic ack_d;
    logic wait_q;
    logic wait_d;
    logic [ictr_pkg::DATA_W-1:0] rdata_q;
    logic [ictr_pkg::DATA_W-1:0] rdata_d;
    logic ext_mode_q;
    logic ext_mode_d;
    logic [ictr_pkg::REG_W-1:0] ofs_word;
    logic [ictr_pkg::REG_W-1:0] fs_word;
    logic [ictr_pkg::OFS_MAG_W-1:0] stored_mag;
    logic stored_neg;
    logic [ictr_pkg::FS_W-1:0] stored_fs;
    logic [ictr_pkg::OFS_MAG_W-1:0] out_mag_q;
    logic [ictr_pkg::OFS_MAG_W-1:0] out_mag_d;
    logic out_neg_q;
    logic out_neg_d;
    logic [ictr_pkg::FS_W-1:0] out_fs_q;
    logic [ictr_pkg::FS_W-1:0] out_fs_d;

    ////////////////////////////////////////////////////////////////////////
    // Address decode and write strobes
    wire [ictr_pkg::ADDR_W-1:0] idx = AVS_ADDRESS[ictr_pkg::ADDR_W+WORD_LSB-1:WORD_LSB];
    wire hit_ofs = f_hit(idx, ictr_pkg::IDX_OFFSET);
    wire hit_fs = f_hit(idx, ictr_pkg::IDX_FSADJ);
    wire hit_mode = f_hit(idx, ictr_pkg::IDX_MODE);
    wire hit_stat = f_hit(idx, ictr_pkg::IDX_STATUS);
    wire any_req = AVS_READ | AVS_WRITE;
    // New only while no answer is out, so a held request is served once
    wire req = any_req & ~ack_q;
    // Low two byte lanes carry the 16-bit word; partial writes are dropped
    wire lanes_ok = &AVS_BYTEENABLE[LANE_W-1:0];
    // Writes land on the answer edge, when the master sees waitrequest low
    wire wr_fire = AVS_WRITE & ack_q & lanes_ok;
    wire wr_ofs = wr_fire & hit_ofs;
    wire wr_fs = wr_fire & hit_fs;
    wire wr_mode = wr_fire & hit_mode;
    wire [ictr_pkg::REG_W-1:0] wdata16 = AVS_WRITEDATA[ictr_pkg::REG_W-1:DATA_LSB];
    wire mode_bit = AVS_WRITEDATA[MODE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Read path
    wire [ictr_pkg::DATA_W-1:0] rd_mode = f_mode(ext_mode_q);
    wire [ictr_pkg::DATA_W-1:0] rd_stat = f_status(stored_fs, stored_neg, stored_mag);
    // Trim registers read as zero: write-only by design
    wire [ictr_pkg::DATA_W-1:0] rd_mux =
        hit_mode ? rd_mode :
        hit_stat ? rd_stat :
        ictr_pkg::RD_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, answer on the second edge
    assign ack_d = req;
    // Own flop for waitrequest, so the port is a register output
    assign wait_d = ~req;
    // Read data zero outside a read answer
    assign rdata_d = (AVS_READ & req) ? rd_mux : ictr_pkg::RD_ZERO;
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= wait_d;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_q <= ictr_pkg::RD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode flag: reset selects normal mode, where trim has no effect
    assign ext_mode_d = wr_mode ? mode_bit : ext_mode_q;
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ext_mode_q <= 1'b0;
        end else begin
            ext_mode_q <= ext_mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim storage; fill bits 6:0 are the host's duty and ignored here
    ictr_wr_latch #(.RST_VAL(ictr_pkg::OFFSET_RST)) u_ofs (
        .clk(SYS_CLK),
        .rst(RST),
        .wr_en(wr_ofs),
        .wr_data(wdata16),
        .value(ofs_word)
    );
    ictr_wr_latch #(.RST_VAL(ictr_pkg::FSADJ_RST)) u_fs (
        .clk(SYS_CLK),
        .rst(RST),
        .wr_en(wr_fs),
        .wr_data(wdata16),
        .value(fs_word)
    );
    assign stored_mag = ofs_word[ictr_pkg::OFS_MAG_HI:ictr_pkg::OFS_MAG_LO];
    assign stored_neg = ofs_word[ictr_pkg::OFS_SIGN];
    assign stored_fs = fs_word[ictr_pkg::FS_HI:ictr_pkg::FS_LO];

    ////////////////////////////////////////////////////////////////////////
    // Trim outputs, one cycle behind the stored word
    // Normal mode forces zero offset and midscale code
    assign out_mag_d = ext_mode_q ? stored_mag : ictr_pkg::OFS_MAG_ZERO;
    assign out_neg_d = ext_mode_q & stored_neg;
    // Analog side maps the code linearly, 560..840 mV around 700 mV
    assign out_fs_d = ext_mode_q ? stored_fs : ictr_pkg::FS_MIDSCALE;
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            out_mag_q <= ictr_pkg::OFS_MAG_ZERO;
        end else begin
            out_mag_q <= out_mag_d;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            out_neg_q <= 1'b0;
        end else begin
            out_neg_q <= out_neg_d;
        end
    end
    // New code passes straight on; no calibration request exists here
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            out_fs_q <= ictr_pkg::FS_MIDSCALE;
        end else begin
            out_fs_q <= out_fs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ports
    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;
    assign OFFSET_MAG = out_mag_q;
    assign OFFSET_NEG = out_neg_q;
    assign FS_CODE = out_fs_q;
endmodule
`default_nettype wire

/* sim/ictr_top_chk.sv */
// Checker: handshake and trim output assertions
`timescale 1ns/1ps
`default_nettype none
module ictr_top_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic [7:0] OFFSET_MAG,
    input wire logic OFFSET_NEG,
    input wire logic [8:0] FS_CODE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire wr_done = AVS_WRITE && !AVS_WAITREQUEST;
    ////////////////////////////////////////
    property p_rst_mag; $fell(RST) |-> OFFSET_MAG == 8'h00; endproperty
    a_rst_mag: assert property (p_rst_mag) else $error("magnitude not zero");
    property p_rst_neg; $fell(RST) |-> !OFFSET_NEG; endproperty
    a_rst_neg: assert property (p_rst_neg) else $error("sign not zero");
    property p_rst_fs; $fell(RST) |-> FS_CODE == 9'h100; endproperty
    a_rst_fs: assert property (p_rst_fs) else $error("code not midscale");
    property p_wait_one; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer late");
    property p_wait_pulse; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
    property p_idle; !AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    // A code change only two edges after a write, never on its own
    property p_fs_cause; !$stable(FS_CODE) |-> $past(wr_done, 2); endproperty
    a_fs_cause: assert property (p_fs_cause) else $error("code moved unasked");
    property p_mag_cause; !$stable(OFFSET_MAG) |-> $past(wr_done, 2); endproperty
    a_mag_cause: assert property (p_mag_cause) else $error("offset moved unasked");
endmodule
bind ictr_top ictr_top_chk u_chk (.SYS_CLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
    .OFFSET_MAG, .OFFSET_NEG, .FS_CODE);
`default_nettype wire

/* sim/ictr_top_tb.sv */
// Testbench: trim register writes, reads and output checks
`timescale 1ns/1ps
`default_nettype none
module ictr_top_tb;
    logic SYS_CLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [5:0] AVS_ADDRESS = 6'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd_q;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic AVS_WAITREQUEST, OFFSET_NEG;
    logic [7:0] OFFSET_MAG;
    logic [8:0] FS_CODE;
    int mismatches = 0, compares = 0;
    ictr_top uut (.SYS_CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .OFFSET_MAG, .OFFSET_NEG, .FS_CODE);
    initial forever #2 SYS_CLK = ~SYS_CLK;
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Edge first, so a release and the next request never share a step
    task automatic xfer(input logic r, input logic [5:0] a, input logic [31:0] d,
            input logic [3:0] be = 4'hF);
        @(posedge SYS_CLK);
        AVS_READ <= r;
        AVS_WRITE <= !r;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge SYS_CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd_q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    // Outputs lag the latch edge by one cycle
    task automatic trim(input logic [17:0] e);
        repeat (2) @(posedge SYS_CLK);
        chk("trim", {14'h0, e}, {14'h0, OFFSET_MAG, OFFSET_NEG, FS_CODE});
    endtask
    task automatic summarize;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge SYS_CLK);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge SYS_CLK);
        RST <= 1'b0;
        trim({8'h00, 1'b0, 9'h100});
        xfer(1'b0, 6'h08, 32'h0000_ABFF);
        xfer(1'b0, 6'h0C, 32'h0000_FFFF);
        trim({8'h00, 1'b0, 9'h100});
        xfer(1'b1, 6'h08, 32'h0);
        chk("offset read", 32'h0, rd_q);
        xfer(1'b1, 6'h14, 32'h0);
        chk("status", 32'h0003_FFAB, rd_q);
        xfer(1'b0, 6'h10, 32'h1);
        trim({8'hAB, 1'b1, 9'h1FF});
        xfer(1'b0, 6'h0C, 32'h0000_007F);
        trim({8'hAB, 1'b1, 9'h000});
        xfer(1'b0, 6'h0C, 32'h0000_C07F, 4'h1);
        xfer(1'b0, 6'h3C, 32'h0000_FFFF);
        xfer(1'b0, 6'h08, 32'h0000_017F);
        trim({8'h01, 1'b0, 9'h000});
        xfer(1'b1, 6'h3C, 32'h0);
        chk("unmapped read", 32'h0, rd_q);
        xfer(1'b0, 6'h0C, 32'h0000_807F);
        trim({8'h01, 1'b0, 9'h100});
        xfer(1'b0, 6'h0C, 32'h0000_C07F);
        trim({8'h01, 1'b0, 9'h180});
        // Second reset in mid-run: stored words and mode go back to nominal
        RST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'b0;
        trim({8'h00, 1'b0, 9'h100});
        xfer(1'b1, 6'h14, 32'h0);
        chk("status after reset", 32'h0002_0000, rd_q);
        xfer(1'b1, 6'h10, 32'h0);
        chk("mode after reset", 32'h0, rd_q);
        summarize();
    end
endmodule
`default_nettype wire
